// ===== rtl/sas_pkg.sv
package sas_pkg;

   // register byte offsets
   localparam logic [11:0] SAS_CTRL_OFS   = 12'h000;
   localparam logic [11:0] SAS_CFG_OFS    = 12'h004;
   localparam logic [11:0] SAS_DELAY_OFS  = 12'h008;
   localparam logic [11:0] SAS_STATUS_OFS = 12'h00C;
   localparam logic [11:0] SAS_RESULT_OFS = 12'h010;
   localparam logic [11:0] SAS_TOUCH_OFS  = 12'h014;

   // ctrl fields
   localparam int SAS_CTRL_START_BIT = 0;
   localparam int SAS_CTRL_EXTEN_BIT = 1;
   localparam int SAS_CTRL_IEN_BIT   = 2;

   // cfg fields
   localparam int SAS_CFG_CH_LSB   = 0;
   localparam int SAS_CFG_DIFF_BIT = 3;
   localparam int SAS_CFG_PREF_LSB = 4;
   localparam int SAS_CFG_NREF_LSB = 6;
   localparam int SAS_CFG_EXTF_BIT = 8;

   // status fields
   localparam int SAS_ST_DONE_BIT = 0;
   localparam int SAS_ST_BUSY_BIT = 1;
   localparam int SAS_ST_PEN_BIT  = 2;

   // reset values
   localparam logic [8:0]  SAS_CFG_RST   = 9'h000;
   localparam logic [15:0] SAS_DELAY_RST = 16'h0000;
   localparam logic [7:0]  SAS_TOUCH_RST = 8'h00;

   // conversion time
   localparam int SAS_CONV_NS     = 15000;
   localparam int SAS_CLK_NS      = 20;
   localparam int SAS_CONV_CYCLES = (SAS_CONV_NS + SAS_CLK_NS - 1) / SAS_CLK_NS;

   typedef enum logic [1:0] {
      SAS_PREF_SUPPLY,
      SAS_PREF_EXTPIN,
      SAS_PREF_IN0,
      SAS_PREF_IN3
   } sas_pref_t;

   typedef enum logic [1:0] {
      SAS_NREF_SUPPLY,
      SAS_NREF_IN1,
      SAS_NREF_IN2,
      SAS_NREF_RSVD
   } sas_nref_t;

   // analog front-end control
   typedef struct packed {
      logic [2:0] channel;
      logic       diff_mode;
      sas_pref_t  pos_ref;
      sas_nref_t  neg_ref;
      logic       ext_filter;
   } sas_mux_t;

   // touch drivers: high side and low side per pin
   typedef struct packed {
      logic [3:0] drive_high;
      logic [3:0] drive_low;
   } sas_touch_t;

endpackage

// ===== rtl/sas_sequencer.sv
`timescale 1ns/1ps

// Operation
// - select one of eight inputs and produce a twelve-bit result
// - single-ended mode or differential mode using four input pairs
// - single-ended: convert requested channel once, then stop
// - differential: convert requested pair once, then stop
// - positive reference: supply, external pin, input 0 or input 3
// - negative reference: supply, input 1 or input 2
// - external trigger starts conversion after programmable delay
// - pollable done flag with optional interrupt on completion
// - route mux output and converter input to pins for filtering
// - software-controlled low-resistance drivers on four touch pins
// - detect pen-down and report it as status
module sas_sequencer
   import sas_pkg::*;
#(
   parameter int DELAY_W     = 16,
   parameter int CONV_CYCLES = SAS_CONV_CYCLES
) (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   // trigger and done
   input  wire logic        ext_trigger,
   output      logic        done_irq,
   // converter core
   output      sas_mux_t    mux_ctrl,
   output      logic        conv_start,
   input  wire logic        conv_done,
   input  wire logic [11:0] conv_result,
   // touchscreen
   output      sas_touch_t  touch_drive,
   input  wire logic        pen_down_in
);

   initial begin
      if (DELAY_W < 1 || DELAY_W > 16) begin
         $error("DELAY_W must be 1 to 16");
      end
      if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin
         $error("CONV_CYCLES must be 1 to 65535");
      end
   end

   typedef enum {SAS_IDLE, SAS_WAIT, SAS_CONV} sas_state_t;

   localparam logic [15:0] CONV_LIMIT = 16'(CONV_CYCLES - 1);

   sas_state_t          state_reg;
   logic [8:0]          cfg_reg;
   logic [DELAY_W-1:0]  delay_reg;
   logic [DELAY_W-1:0]  delay_cnt_reg;
   logic [15:0]         conv_cnt_reg;
   logic                exten_reg;
   logic                ien_reg;
   logic                done_reg;
   logic [11:0]         result_reg;
   logic [7:0]          touch_reg;
   logic                pen_reg;
   logic                trig_prev_reg;
   logic                conv_start_reg;

   // address decode
   logic                hit_ctrl;
   logic                hit_cfg;
   logic                hit_delay;
   logic                hit_status;
   logic                hit_result;
   logic                hit_touch;

   logic                wr_en;
   logic                rd_setup;
   logic                addr_ok;
   logic                sw_start;
   logic                trig_edge;
   logic                start_req;
   logic                delayed_go;
   logic                launch;
   logic                finish;
   logic                busy;
   logic [31:0]         ctrl_word;
   logic [31:0]         status_word;
   logic [31:0]         rd_mux;

   // apb answers in the access cycle, no wait states
   assign pready  = 1'b1;

   // one hit per register
   always_comb begin
      hit_ctrl   = 1'b0;
      hit_cfg    = 1'b0;
      hit_delay  = 1'b0;
      hit_status = 1'b0;
      hit_result = 1'b0;
      hit_touch  = 1'b0;
      if (paddr == SAS_CTRL_OFS) begin
         hit_ctrl = 1'b1;
      end else if (paddr == SAS_CFG_OFS) begin
         hit_cfg = 1'b1;
      end else if (paddr == SAS_DELAY_OFS) begin
         hit_delay = 1'b1;
      end else if (paddr == SAS_STATUS_OFS) begin
         hit_status = 1'b1;
      end else if (paddr == SAS_RESULT_OFS) begin
         hit_result = 1'b1;
      end else if (paddr == SAS_TOUCH_OFS) begin
         hit_touch = 1'b1;
      end
   end

   assign addr_ok  = hit_ctrl || hit_cfg || hit_delay || hit_status || hit_result || hit_touch;
   assign pslverr  = psel && penable && !addr_ok;
   assign wr_en    = psel && penable && pwrite && addr_ok;
   assign rd_setup = psel && !penable && !pwrite;

   assign busy        = (state_reg != SAS_IDLE);
   assign ctrl_word   = {29'h0, ien_reg, exten_reg, 1'b0};
   assign status_word = {29'h0, pen_reg, busy, done_reg};

   assign sw_start  = wr_en && (paddr == SAS_CTRL_OFS) && pwdata[SAS_CTRL_START_BIT];
   assign trig_edge = exten_reg && ext_trigger && !trig_prev_reg;
   assign start_req = (sw_start || trig_edge) && (state_reg == SAS_IDLE);
   assign finish    = (state_reg == SAS_CONV)
                   && (conv_done || conv_cnt_reg == CONV_LIMIT);

   // trigger with nonzero delay waits first; software start never waits
   assign delayed_go = trig_edge && !sw_start && (delay_reg != '0);
   assign launch     = (start_req && !delayed_go)
                    || (state_reg == SAS_WAIT && delay_cnt_reg == '0);

   // control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exten_reg <= 1'b0;
         ien_reg   <= 1'b0;
      end else if (wr_en && hit_ctrl) begin
         exten_reg <= pwdata[SAS_CTRL_EXTEN_BIT];
         ien_reg   <= pwdata[SAS_CTRL_IEN_BIT];
      end
   end

   // front-end configuration register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= SAS_CFG_RST;
      end else if (wr_en && hit_cfg) begin
         cfg_reg <= pwdata[8:0];
      end
   end

   // start delay register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delay_reg <= DELAY_W'(SAS_DELAY_RST);
      end else if (wr_en && hit_delay) begin
         delay_reg <= pwdata[DELAY_W-1:0];
      end
   end

   // touch driver register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         touch_reg <= SAS_TOUCH_RST;
      end else if (wr_en && hit_touch) begin
         touch_reg <= pwdata[7:0];
      end
   end

   // trigger edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_prev_reg <= 1'b0;
      end else begin
         trig_prev_reg <= ext_trigger;
      end
   end

   // sequencer: one conversion per start, then back to idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SAS_IDLE;
      end else begin
         case (state_reg)
            SAS_IDLE: begin
               if (start_req && delayed_go) begin
                  state_reg <= SAS_WAIT;
               end else if (start_req) begin
                  state_reg <= SAS_CONV;
               end
            end
            SAS_WAIT: begin
               if (delay_cnt_reg == '0) begin
                  state_reg <= SAS_CONV;
               end
            end
            SAS_CONV: begin
               if (finish) begin
                  state_reg <= SAS_IDLE;
               end
            end
            default: begin
               state_reg <= SAS_IDLE;
            end
         endcase
      end
   end

   // start delay countdown
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delay_cnt_reg <= '0;
      end else if (start_req && delayed_go) begin
         delay_cnt_reg <= delay_reg - DELAY_W'(1);
      end else if (state_reg == SAS_WAIT && delay_cnt_reg != '0) begin
         delay_cnt_reg <= delay_cnt_reg - DELAY_W'(1);
      end
   end

   // conversion timeout, ends the conversion if the core stays silent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_cnt_reg <= 16'h0000;
      end else if (launch) begin
         conv_cnt_reg <= 16'h0000;
      end else if (state_reg == SAS_CONV && !finish) begin
         conv_cnt_reg <= conv_cnt_reg + 16'h0001;
      end
   end

   // one-cycle start pulse to the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_start_reg <= 1'b0;
      end else begin
         conv_start_reg <= launch;
      end
   end

   // done flag: set on finish wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
      end else if (finish) begin
         done_reg <= 1'b1;
      end else if (start_req) begin
         done_reg <= 1'b0;
      end
   end

   // result capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_reg <= 12'h000;
      end else if (finish) begin
         result_reg <= conv_result;
      end
   end

   // pen-down status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pen_reg <= 1'b0;
      end else begin
         pen_reg <= pen_down_in;
      end
   end

   // read data select
   always_comb begin
      rd_mux = 32'h00000000;
      if (hit_ctrl) begin
         rd_mux = ctrl_word;
      end else if (hit_cfg) begin
         rd_mux = {23'h0, cfg_reg};
      end else if (hit_delay) begin
         rd_mux = 32'(delay_reg);
      end else if (hit_status) begin
         rd_mux = status_word;
      end else if (hit_result) begin
         rd_mux = {20'h0, result_reg};
      end else if (hit_touch) begin
         rd_mux = {24'h0, touch_reg};
      end
   end

   // read data register, loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

   assign done_irq   = done_reg && ien_reg;
   assign conv_start = conv_start_reg;

   // front-end controls; differential uses channel[1:0] as pair index
   assign mux_ctrl.channel    = cfg_reg[SAS_CFG_CH_LSB +: 3];
   assign mux_ctrl.diff_mode  = cfg_reg[SAS_CFG_DIFF_BIT];
   assign mux_ctrl.pos_ref    = sas_pref_t'(cfg_reg[SAS_CFG_PREF_LSB +: 2]);
   assign mux_ctrl.neg_ref    = sas_nref_t'(cfg_reg[SAS_CFG_NREF_LSB +: 2]);
   assign mux_ctrl.ext_filter = cfg_reg[SAS_CFG_EXTF_BIT];

   // never drive high and low side of one pin together
   assign touch_drive.drive_high = touch_reg[7:4] & ~touch_reg[3:0];
   assign touch_drive.drive_low  = touch_reg[3:0];

endmodule

// ===== sim/sas_core_model.sv
`timescale 1ns/1ps
module sas_core_model #(
   parameter int LAT = 6
) (
   input  wire logic        clk,
   input  wire logic        start,
   output      logic        done   = 1'b0,
   output      logic [11:0] result = 12'h000
);
   int cnt = 0;
   // result bus toggles except in the finishing cycle
   always_ff @(posedge clk) begin
      done   <= 1'b0;
      result <= ~result;
      if (start) begin
         cnt <= LAT;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      if (!start && cnt == 1) begin
         done   <= 1'b1;
         result <= 12'hA5C;
      end
   end
endmodule

// ===== sim/sas_sequencer_chk.sv
`timescale 1ns/1ps
module sas_seq_chk
   import sas_pkg::*;
#(parameter int DELAY_W = 16, parameter int CONV_CYCLES = 8) (
   input wire logic        pclk, presetn, psel, penable, pwrite, ext_trigger, pen_down_in,
   input wire logic [11:0] paddr, conv_result,
   input wire logic [31:0] pwdata, prdata,
   input wire logic        pready, pslverr, done_irq, conv_start, conv_done,
   input wire sas_mux_t    mux_ctrl,
   input wire sas_touch_t  touch_drive
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [31:0] wd;
   wire         acc = psel && penable;
   always_ff @(posedge pclk) wd <= pwdata;
   property p_once; conv_start |=> !conv_start [*5]; endproperty
   a_once: assert property (p_once) else $error("start repeated");
   property p_clr; conv_start |-> !done_irq; endproperty
   a_clr: assert property (p_clr) else $error("done kept at start");
   property p_irq; $rose(done_irq) |-> $past(conv_done); endproperty
   a_irq: assert property (p_irq) else $error("irq without finish");
   property p_cfg; acc && pwrite && paddr == SAS_CFG_OFS |=>
      {mux_ctrl.channel, mux_ctrl.pos_ref, mux_ctrl.neg_ref} ==
      {wd[2:0], wd[5:4], wd[7:6]}; endproperty
   a_cfg: assert property (p_cfg) else $error("mux select wrong");
   property p_touch; acc && pwrite && paddr == SAS_TOUCH_OFS |=>
      touch_drive == {wd[7:4] & ~wd[3:0], wd[3:0]}; endproperty
   a_touch: assert property (p_touch) else $error("touch drive wrong");
   property p_pen; acc && !pwrite && paddr == SAS_STATUS_OFS |->
      prdata[2] == $past(pen_down_in, 2); endproperty
   a_pen: assert property (p_pen) else $error("pen status wrong");
   property p_err; acc && !pwrite && paddr > SAS_TOUCH_OFS |-> pslverr && prdata == 0;
   endproperty
   a_err: assert property (p_err) else $error("unmapped read accepted");
   property p_rdy; pready; endproperty
   a_rdy: assert property (p_rdy) else $error("wait state seen");
   c_start: cover property (conv_start);
   c_irq: cover property (done_irq);
   c_err: cover property (pslverr);
endmodule
bind sas_sequencer sas_seq_chk #(.DELAY_W(DELAY_W), .CONV_CYCLES(CONV_CYCLES)) chk_u (.*);

// ===== sim/sas_sequencer_tb.sv
`timescale 1ns/1ps
module sas_sequencer_tb;
   import sas_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        ext_trigger = 0, pen_down_in = 0, err;
   logic [11:0] paddr = 0, conv_result;
   logic [31:0] pwdata = 0, prdata, rd, w;
   logic        pready, pslverr, done_irq, conv_start, conv_done;
   sas_mux_t    mux_ctrl;
   sas_touch_t  touch_drive;
   int          fail_count = 0, tests_run = 0, starts = 0, i, n;
   sas_sequencer #(.CONV_CYCLES(8)) dut_u (.*);
   sas_core_model #(.LAT(4)) core_u (.clk(pclk), .start(conv_start), .done(conv_done),
      .result(conv_result));
   initial forever #10 pclk = ~pclk;
   always @(posedge pclk) if (conv_start === 1'b1) starts++;
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin fail_count++; results(); end
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task automatic wdone();
      for (n = 0; n < 40; n++) begin
         apb(0, SAS_STATUS_OFS, 0);
         if (rd[0] === 1'b1) break;
      end
      if (n >= 40) begin fail_count++; results(); end
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      for (i = 4; i <= 20; i += 4) begin apb(0, 12'(i), 0); chk(rd, 0, "reset value"); end
      for (i = 0; i < 12; i++) begin
         w = {23'h0, 1'(i >> 1), 2'(i % 3), 2'(i % 4), 1'(i), 3'(i % 8)};
         apb(1, SAS_CFG_OFS, w);
         chk(mux_ctrl, {w[2:0], w[3], w[5:4], w[7:6], w[8]}, "mux");
      end
      apb(1, SAS_CTRL_OFS, 5);
      apb(0, SAS_STATUS_OFS, 0); chk(rd[1:0], 2, "busy status");
      apb(1, SAS_CTRL_OFS, 5);
      wdone(); chk(starts, 1, "start count");
      apb(0, SAS_RESULT_OFS, 0); chk(rd, 32'hA5C, "result");
      chk(done_irq, 1, "irq");
      apb(1, SAS_CFG_OFS, 32'h0D);
      apb(1, SAS_CTRL_OFS, 1);
      wdone(); chk(starts, 2, "diff count");
      chk(done_irq, 0, "masked irq");
      apb(1, SAS_DELAY_OFS, 5); apb(1, SAS_CTRL_OFS, 2);
      ext_trigger <= 1;
      n = 0;
      do begin @(negedge pclk); n++; end while (conv_start !== 1'b1 && n < 40);
      chk(n > 5 && n <= 9, 1, "trigger delay");
      @(posedge pclk);
      ext_trigger <= 0;
      wdone(); chk(starts, 3, "trigger count");
      apb(1, SAS_TOUCH_OFS, 32'hF3); chk(touch_drive, 8'hC3, "touch");
      apb(0, SAS_TOUCH_OFS, 0); chk(rd, 32'hF3, "touch reg");
      pen_down_in <= 1;
      repeat (2) @(posedge pclk);
      apb(0, SAS_STATUS_OFS, 0); chk(rd[2], 1, "pen");
      apb(0, 12'h018, 0); chk(err, 1, "unmapped error");
      chk(rd, 0, "unmapped data");
      results();
   end
endmodule
